// *** core/gmo_gauge.sv ***
// Measurement scheduling, over-temperature flags and user data area of the gauge
// Functional notes
// [R1] Cell voltage sampled, refreshed every second
// [R2] Positive sense difference charging, negative discharging
// [R3] Charge and discharge applied to capacity each second
// [R4] Four-reading history gives current each second
// [R5] Temperature source chosen by sensor select bit
// [R6] Selected temperature refreshed every second
// [R7] Charge over-temperature flag set after hold
// [R8] Charge flag clears at release level
// [R9] Zero hold time disables that detection
// [R10] Discharge inhibit request set after hold
// [R11] Inhibit request clears at release level
// [R12] 96 byte user area, three 32-byte blocks
// [R13] Host issues commands to read and write
// [R14] Host gives subclass and offset for access
// [R15] Percent is charge over maximum capacity
// [R16] Maximum capacity updated after full discharge
// [R17] One tick from free divider updates readings, capacity, percent and over-temperature flags
`timescale 1ns/1ps
`default_nettype none
module gmo_gauge #(
   parameter int unsigned TICK_CYCLES = gmo_pkg::TICK_CYCLES,
   parameter int unsigned W = gmo_pkg::MEAS_W
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic signed [W-1:0] cell_voltage_pin,
   input wire logic signed [W-1:0] sense_pos_pin,
   input wire logic signed [W-1:0] sense_neg_pin,
   input wire logic signed [W-1:0] thermistor_input,
   input wire logic signed [W-1:0] internal_temp,
   input wire logic internal_sensor_select,
   input wire logic charge_fault_enable,
   input wire logic signed [W-1:0] charge_overtemp_threshold,
   input wire logic [7:0] charge_overtemp_hold_time,
   input wire logic signed [W-1:0] charge_overtemp_release_level,
   input wire logic signed [W-1:0] charge_current_limit,
   input wire logic signed [W-1:0] discharge_overtemp_threshold,
   input wire logic [7:0] discharge_overtemp_hold_time,
   input wire logic signed [W-1:0] discharge_overtemp_release_level,
   input wire logic signed [W-1:0] discharge_current_limit,
   input wire logic full_discharge,
   input wire logic flash_wr,
   input wire logic [gmo_pkg::SUBCLASS_W-1:0] flash_subclass,
   input wire logic [gmo_pkg::OFFSET_W-1:0] flash_offset,
   input wire logic [7:0] flash_wr_data,
   output logic [7:0] flash_rd_data,
   output logic flash_addr_ok,
   output logic measure_tick,
   output logic signed [W-1:0] voltage_value,
   output logic signed [W-1:0] temperature_value,
   output logic signed [W-1:0] mean_current_readback,
   output logic [W-1:0] capacity_left_value,
   output logic [W-1:0] max_capacity_value,
   output logic [7:0] relative_charge_percent,
   output logic charging,
   output logic discharging,
   output logic charge_overtemp_flag,
   output logic discharge_inhibit_request
);
   // ****************************************************************
   // Input synchronisers (two stages, pins are asynchronous)
   // ****************************************************************
   localparam int NSYNC = 6;
   logic [W-1:0] s1 [NSYNC];
   logic [W-1:0] s2 [NSYNC];
   logic [W-1:0] raw [NSYNC];
   assign raw[0] = cell_voltage_pin;
   assign raw[1] = sense_pos_pin;
   assign raw[2] = sense_neg_pin;
   assign raw[3] = thermistor_input;
   assign raw[4] = internal_temp;
   assign raw[5] = {{(W-1){1'b0}}, full_discharge};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk_sys) begin
            s1[gi] <= raw[gi];
            s2[gi] <= s1[gi];
         end
      end
   endgenerate

   logic signed [W-1:0] vbat_s, spos_s, sneg_s, therm_s, it_s;
   logic full_dsg_s;
   assign vbat_s = s2[0];
   assign spos_s = s2[1];
   assign sneg_s = s2[2];
   assign therm_s = s2[3];
   assign it_s = s2[4];
   assign full_dsg_s = s2[5][0];

   // ****************************************************************
   // One second tick divider
   // ****************************************************************
   logic [31:0] div_cnt, next_div_cnt;
   logic tick;
   always_comb begin
      tick = (div_cnt == 32'(TICK_CYCLES - 1));
      next_div_cnt = tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001; // [R17]
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_cnt <= 32'h0000_0000;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   // ****************************************************************
   // Measurement state
   // ****************************************************************
   logic signed [W-1:0] sense_diff;
   logic signed [W+1:0] acc, next_acc;
   logic signed [W-1:0] hist [gmo_pkg::HIST_DEPTH];
   logic signed [W-1:0] next_hist [gmo_pkg::HIST_DEPTH];
   logic signed [W+1:0] hist_sum;
   logic signed [W-1:0] next_volt, next_temp, next_cur;
   logic [W-1:0] next_cap, next_maxcap;
   logic [7:0] next_pct;
   logic full_dsg_d, next_full_dsg_d;
   logic signed [W+1:0] cap_wide;
   gmo_pkg::gmo_activity_t act, next_act;

   always_comb begin
      sense_diff = W'(spos_s - sneg_s);
      next_act = act;
      if (sense_diff > 0) begin
         next_act = gmo_pkg::GMO_CHARGE; // [R2]
      end else if (sense_diff < 0) begin
         next_act = gmo_pkg::GMO_DISCHARGE; // [R2]
      end else begin
         next_act = gmo_pkg::GMO_IDLE;
      end
      next_acc = acc + (W+2)'(sense_diff);
      next_volt = voltage_value;
      next_temp = temperature_value;
      next_cur = mean_current_readback;
      next_cap = capacity_left_value;
      next_maxcap = max_capacity_value;
      next_pct = relative_charge_percent;
      next_full_dsg_d = full_dsg_s;
      for (int i = 0; i < gmo_pkg::HIST_DEPTH; i++) begin
         next_hist[i] = hist[i];
      end
      hist_sum = '0;
      for (int i = 0; i < gmo_pkg::HIST_DEPTH; i++) begin
         hist_sum = hist_sum + (W+2)'(hist[i]);
      end
      cap_wide = (W+2)'(signed'({2'b00, capacity_left_value})) + acc;
      if (tick) begin
         next_volt = vbat_s; // [R1]
         next_temp = internal_sensor_select ? it_s : therm_s; // [R5] [R6]
         next_hist[0] = W'(acc); // [R4]
         for (int i = 1; i < gmo_pkg::HIST_DEPTH; i++) begin
            next_hist[i] = hist[i-1];
         end
         next_cur = W'((hist_sum - (W+2)'(hist[gmo_pkg::HIST_DEPTH-1]) + acc) >>> 2); // [R4]
         if (cap_wide < 0) begin
            next_cap = '0; // [R3]
         end else if (cap_wide > (W+2)'(signed'({2'b00, max_capacity_value}))) begin
            next_cap = max_capacity_value;
         end else begin
            next_cap = W'(cap_wide); // [R3]
         end
         next_acc = (W+2)'(sense_diff); // [R3] Tick cycle opens the next window
         if (max_capacity_value != '0) begin
            next_pct = 8'((32'(next_cap) * 32'(gmo_pkg::PERCENT_FULL))
                          / 32'(max_capacity_value)); // [R15]
         end
      end
      if (full_dsg_s && !full_dsg_d) begin
         next_maxcap = (capacity_left_value == '0) ? max_capacity_value
                       : capacity_left_value; // [R16]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         act <= gmo_pkg::GMO_IDLE;
         acc <= '0;
         voltage_value <= '0;
         temperature_value <= '0;
         mean_current_readback <= '0;
         capacity_left_value <= gmo_pkg::CAP_RESET;
         max_capacity_value <= gmo_pkg::MAXCAP_RESET;
         relative_charge_percent <= 8'h00;
         full_dsg_d <= 1'b0;
         for (int i = 0; i < gmo_pkg::HIST_DEPTH; i++) begin
            hist[i] <= '0;
         end
      end else begin
         act <= next_act;
         acc <= next_acc;
         voltage_value <= next_volt;
         temperature_value <= next_temp;
         mean_current_readback <= next_cur;
         capacity_left_value <= next_cap;
         max_capacity_value <= next_maxcap;
         relative_charge_percent <= next_pct;
         full_dsg_d <= next_full_dsg_d;
         for (int i = 0; i < gmo_pkg::HIST_DEPTH; i++) begin
            hist[i] <= next_hist[i];
         end
      end
   end

   assign charging = (act == gmo_pkg::GMO_CHARGE);
   assign discharging = (act == gmo_pkg::GMO_DISCHARGE);
   assign measure_tick = tick;

   // ****************************************************************
   // Over-temperature detection, counted in seconds
   // ****************************************************************
   logic [7:0] chg_cnt, next_chg_cnt, dsg_cnt, next_dsg_cnt;
   logic next_chg_flag, next_dreq;
   always_comb begin
      next_chg_cnt = chg_cnt;
      next_dsg_cnt = dsg_cnt;
      next_chg_flag = charge_overtemp_flag;
      next_dreq = discharge_inhibit_request;
      if (tick) begin
         if (charge_overtemp_hold_time == 8'h00) begin
            next_chg_cnt = 8'h00; // [R9]
            next_chg_flag = 1'b0; // [R9]
         end else if (next_temp <= charge_overtemp_release_level) begin
            next_chg_cnt = 8'h00;
            next_chg_flag = 1'b0; // [R8]
         end else if (charging && next_temp >= charge_overtemp_threshold) begin
            if (chg_cnt < charge_overtemp_hold_time) begin
               next_chg_cnt = chg_cnt + 8'h01;
            end
            if (chg_cnt + 8'h01 >= charge_overtemp_hold_time
                && next_cur > charge_current_limit && charge_fault_enable) begin
               next_chg_flag = 1'b1; // [R7]
            end
         end else begin
            next_chg_cnt = 8'h00;
         end
         if (discharge_overtemp_hold_time == 8'h00) begin
            next_dsg_cnt = 8'h00; // [R9]
            next_dreq = 1'b0; // [R9]
         end else if (next_temp <= discharge_overtemp_release_level) begin
            next_dsg_cnt = 8'h00;
            next_dreq = 1'b0; // [R11]
         end else if (discharging && next_temp >= discharge_overtemp_threshold) begin
            if (dsg_cnt < discharge_overtemp_hold_time) begin
               next_dsg_cnt = dsg_cnt + 8'h01;
            end
            if (dsg_cnt + 8'h01 >= discharge_overtemp_hold_time
                && next_cur <= -discharge_current_limit) begin
               next_dreq = 1'b1; // [R10]
            end
         end else begin
            next_dsg_cnt = 8'h00;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         chg_cnt <= 8'h00;
         dsg_cnt <= 8'h00;
         charge_overtemp_flag <= 1'b0;
         discharge_inhibit_request <= 1'b0;
      end else begin
         chg_cnt <= next_chg_cnt;
         dsg_cnt <= next_dsg_cnt;
         charge_overtemp_flag <= next_chg_flag;
         discharge_inhibit_request <= next_dreq;
      end
   end

   // ****************************************************************
   // User data area: subclass plus offset addressing
   // ****************************************************************
   logic [7:0] blk_idx;
   logic [gmo_pkg::FLASH_AW-1:0] flash_addr;
   always_comb begin
      blk_idx = flash_subclass - gmo_pkg::SUBCLASS_BASE;
      flash_addr_ok = (blk_idx < 8'(gmo_pkg::FLASH_BLOCKS)); // [R14]
      flash_addr = gmo_pkg::FLASH_AW'({blk_idx[1:0], flash_offset}); // [R12]
   end

   gmo_flash_mem #(
      .DEPTH(gmo_pkg::FLASH_BYTES),
      .AW(gmo_pkg::FLASH_AW)
   ) u_flash (
      .clk_sys(clk_sys),
      .wr_en(flash_wr && flash_addr_ok), // [R13]
      .addr(flash_addr),
      .wr_data(flash_wr_data),
      .rd_data(flash_rd_data)
   );
endmodule
`default_nettype wire

// *** core/gmo_pkg.sv ***
// Package with constants and types of the gauge measurement and over-temperature block
package gmo_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned TICK_S = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
   // ****************************************************************
   // Widths and sizes
   // ****************************************************************
   localparam int unsigned MEAS_W = 16;
   localparam int unsigned HIST_DEPTH = 4;
   localparam int unsigned FLASH_BLOCKS = 3;
   localparam int unsigned FLASH_BLOCK_BYTES = 32;
   localparam int unsigned FLASH_BYTES = FLASH_BLOCKS * FLASH_BLOCK_BYTES;
   localparam int unsigned FLASH_AW = 7;
   localparam int unsigned SUBCLASS_W = 8;
   localparam int unsigned OFFSET_W = 5;
   // ****************************************************************
   // Reset values and fixed constants
   // ****************************************************************
   localparam logic [15:0] CAP_RESET = 16'h0000;
   localparam logic [15:0] MAXCAP_RESET = 16'h03E8;
   localparam logic [7:0] SUBCLASS_BASE = 8'h3A;
   localparam logic [7:0] PERCENT_FULL = 8'h64;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {GMO_IDLE, GMO_DISCHARGE, GMO_CHARGE} gmo_activity_t;
endpackage

// *** core/gmo_flash_mem.sv ***
// User data area memory: byte wide, registered read data
`timescale 1ns/1ps
`default_nettype none
module gmo_flash_mem #(
   parameter int unsigned DEPTH = 96,
   parameter int unsigned AW = 7
) (
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
   end
endmodule
`default_nettype wire

// *** tb/gmo_gauge_monitor.sv ***
// Assertion checker bound to the gauge measurement and over-temperature block
`timescale 1ns/1ps
`default_nettype none
module gmo_gauge_monitor #(
   parameter int unsigned TICK_CYCLES = 100
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic measure_tick,
   input wire logic signed [15:0] voltage_value,
   input wire logic signed [15:0] temperature_value,
   input wire logic signed [15:0] mean_current_readback,
   input wire logic [15:0] capacity_left_value,
   input wire logic [7:0] relative_charge_percent,
   input wire logic charging,
   input wire logic discharging,
   input wire logic charge_overtemp_flag,
   input wire logic discharge_inhibit_request,
   input wire logic [7:0] charge_overtemp_hold_time,
   input wire logic [7:0] discharge_overtemp_hold_time,
   input wire logic [7:0] flash_subclass,
   input wire logic flash_addr_ok
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Cycles since the last tick, restarted with the divider
   logic [31:0] since_tick;
   always_ff @(posedge clk_sys) begin
      if (reset || measure_tick) begin
         since_tick <= 32'h0000_0000;
      end else begin
         since_tick <= since_tick + 32'h0000_0001;
      end
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_tick_period: assert property (measure_tick == (since_tick == 32'(TICK_CYCLES - 1)))
      else $error("measure tick period wrong");
   a_tick_single: assert property (measure_tick |=> !measure_tick [*8])
      else $error("measure tick longer than one cycle");
   a_volt_hold: assert property (!$past(measure_tick) |-> $stable(voltage_value))
      else $error("voltage changed off tick");
   a_temp_hold: assert property (!$past(measure_tick) |-> $stable(temperature_value))
      else $error("temperature changed off tick");
   a_cur_hold: assert property (!$past(measure_tick) |-> $stable(mean_current_readback))
      else $error("current changed off tick");
   a_cap_hold: assert property (!$past(measure_tick) |-> $stable(capacity_left_value))
      else $error("capacity changed off tick");
   a_dir_excl: assert property (!(charging && discharging))
      else $error("charging and discharging together");
   a_flag_on_tick: assert property ($changed(charge_overtemp_flag) |-> $past(measure_tick))
      else $error("charge flag moved off tick");
   a_chg_zero_hold: assert property ((charge_overtemp_hold_time == 8'h00) && !charge_overtemp_flag
      |=> !charge_overtemp_flag)
      else $error("charge flag set with zero hold");
   a_dsg_zero_hold: assert property ((discharge_overtemp_hold_time == 8'h00)
      && !discharge_inhibit_request |=> !discharge_inhibit_request)
      else $error("inhibit request set with zero hold");
   a_subclass_ok: assert property (flash_addr_ok == ((flash_subclass >= 8'h3A)
      && (flash_subclass <= 8'h3C)))
      else $error("address valid flag wrong");
   a_pct_range: assert property (relative_charge_percent <= 8'h64)
      else $error("percent above full");
   c_chg_flag: cover property ($rose(charge_overtemp_flag));
   c_dsg_flag: cover property ($rose(discharge_inhibit_request));
   c_full: cover property (relative_charge_percent == 8'h64);
endmodule
bind gmo_gauge gmo_gauge_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
   .clk_sys(clk_sys), .reset(reset), .measure_tick(measure_tick),
   .voltage_value(voltage_value), .temperature_value(temperature_value),
   .mean_current_readback(mean_current_readback),
   .capacity_left_value(capacity_left_value),
   .relative_charge_percent(relative_charge_percent), .charging(charging),
   .discharging(discharging), .charge_overtemp_flag(charge_overtemp_flag),
   .discharge_inhibit_request(discharge_inhibit_request),
   .charge_overtemp_hold_time(charge_overtemp_hold_time),
   .discharge_overtemp_hold_time(discharge_overtemp_hold_time),
   .flash_subclass(flash_subclass), .flash_addr_ok(flash_addr_ok)
);
`default_nettype wire

// *** tb/gmo_host.sv ***
// Host model issuing user data area writes and reads
`timescale 1ns/1ps
`default_nettype none
module gmo_host (
   input wire logic clk_sys,
   input wire logic [7:0] flash_rd_data,
   output logic flash_wr,
   output logic [7:0] flash_subclass,
   output logic [4:0] flash_offset,
   output logic [7:0] flash_wr_data
);
   initial begin
      flash_wr = 1'b0;
      flash_subclass = 8'h00;
      flash_offset = 5'h00;
      flash_wr_data = 8'h00;
   end
   // Subclass and offset together select the byte
   task wr(input logic [7:0] sc, input logic [4:0] off, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      flash_subclass = sc;
      flash_offset = off;
      flash_wr_data = d;
      flash_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      flash_wr = 1'b0;
      flash_wr_data = ~d;
   endtask
   task rd(input logic [7:0] sc, input logic [4:0] off, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      flash_subclass = sc;
      flash_offset = off;
      @(posedge clk_sys);
      #1;
      d = flash_rd_data;
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the gauge measurement and over-temperature block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int TC = 100;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic signed [15:0] cell_voltage_pin = '0, sense_pos_pin = '0, sense_neg_pin = '0;
   logic signed [15:0] thermistor_input = 16'h0019, internal_temp = '0;
   logic internal_sensor_select = 1'b0, charge_fault_enable = 1'b1, full_discharge = 1'b0;
   logic signed [15:0] charge_overtemp_threshold = 16'h0050, charge_current_limit = 16'h0064;
   logic signed [15:0] charge_overtemp_release_level = 16'h0030;
   logic signed [15:0] discharge_overtemp_threshold = 16'h0050, discharge_current_limit = 16'h012C;
   logic signed [15:0] discharge_overtemp_release_level = 16'h0030;
   logic [7:0] charge_overtemp_hold_time = 8'h02, discharge_overtemp_hold_time = 8'h01;
   logic flash_wr, flash_addr_ok, measure_tick, charging, discharging;
   logic charge_overtemp_flag, discharge_inhibit_request;
   logic [7:0] flash_subclass, flash_wr_data, flash_rd_data, relative_charge_percent, rd;
   logic [4:0] flash_offset;
   logic signed [15:0] voltage_value, temperature_value, mean_current_readback;
   logic [15:0] capacity_left_value, max_capacity_value;
   int errors = 0, compares = 0;
   gmo_gauge #(.TICK_CYCLES(TC)) uut (
      .clk_sys(clk_sys), .reset(reset), .cell_voltage_pin(cell_voltage_pin),
      .sense_pos_pin(sense_pos_pin), .sense_neg_pin(sense_neg_pin),
      .thermistor_input(thermistor_input), .internal_temp(internal_temp),
      .internal_sensor_select(internal_sensor_select),
      .charge_fault_enable(charge_fault_enable),
      .charge_overtemp_threshold(charge_overtemp_threshold),
      .charge_overtemp_hold_time(charge_overtemp_hold_time),
      .charge_overtemp_release_level(charge_overtemp_release_level),
      .charge_current_limit(charge_current_limit),
      .discharge_overtemp_threshold(discharge_overtemp_threshold),
      .discharge_overtemp_hold_time(discharge_overtemp_hold_time),
      .discharge_overtemp_release_level(discharge_overtemp_release_level),
      .discharge_current_limit(discharge_current_limit), .full_discharge(full_discharge),
      .flash_wr(flash_wr), .flash_subclass(flash_subclass), .flash_offset(flash_offset),
      .flash_wr_data(flash_wr_data), .flash_rd_data(flash_rd_data),
      .flash_addr_ok(flash_addr_ok), .measure_tick(measure_tick),
      .voltage_value(voltage_value), .temperature_value(temperature_value),
      .mean_current_readback(mean_current_readback),
      .capacity_left_value(capacity_left_value), .max_capacity_value(max_capacity_value),
      .relative_charge_percent(relative_charge_percent), .charging(charging),
      .discharging(discharging), .charge_overtemp_flag(charge_overtemp_flag),
      .discharge_inhibit_request(discharge_inhibit_request)
   );
   gmo_host host (
      .clk_sys(clk_sys), .flash_rd_data(flash_rd_data), .flash_wr(flash_wr),
      .flash_subclass(flash_subclass), .flash_offset(flash_offset),
      .flash_wr_data(flash_wr_data)
   );
   always #2.5 clk_sys = ~clk_sys;
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_sys iff measure_tick === 1'b1);
      #1;
   endtask
   task pulse_full;
      full_discharge = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      full_discharge = 1'b0;
   endtask
   task test_done;
      if (errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_reset;
      chk(voltage_value, 16'h0000);
      chk(max_capacity_value, 16'h03E8);
      chk(charge_overtemp_flag, 16'h0000);
      chk(discharge_inhibit_request, 16'h0000);
   endtask
   task t_meas;
      cell_voltage_pin = 16'h0E10;
      internal_temp = 16'h0021;
      tick(2);
      chk(voltage_value, 16'h0E10);
      chk(temperature_value, 16'h0019);
      internal_sensor_select = 1'b1;
      tick(2);
      chk(temperature_value, 16'h0021);
      internal_sensor_select = 1'b0;
   endtask
   task t_dsg;
      sense_neg_pin = 16'h0003;
      tick(5);
      chk(mean_current_readback, 16'hFED4);
      chk(capacity_left_value, 16'h0000);
      chk(discharging, 16'h0001);
      chk(charging, 16'h0000);
      chk(relative_charge_percent, 16'h0000);
      chk(discharge_inhibit_request, 16'h0000);
      pulse_full();
      chk(max_capacity_value, 16'h03E8);
      thermistor_input = 16'h0050;
      tick(1);
      chk(discharge_inhibit_request, 16'h0001);
      thermistor_input = 16'h0030;
      tick(1);
      chk(discharge_inhibit_request, 16'h0000);
      discharge_overtemp_hold_time = 8'h00;
      thermistor_input = 16'h0050;
      tick(2);
      chk(discharge_inhibit_request, 16'h0000);
      thermistor_input = 16'h0019;
   endtask
   task t_chg;
      sense_neg_pin = 16'h0000;
      sense_pos_pin = 16'h0002;
      tick(5);
      chk(mean_current_readback, 16'h00C8);
      chk(charging, 16'h0001);
      pulse_full();
      chk(max_capacity_value, 16'h03D9);
      tick(1);
      chk(relative_charge_percent, 16'h0064);
      chk(capacity_left_value, 16'h03D9);
      thermistor_input = 16'h0050;
      tick(1);
      chk(charge_overtemp_flag, 16'h0000);
      tick(1);
      chk(charge_overtemp_flag, 16'h0001);
      thermistor_input = 16'h0030;
      tick(1);
      chk(charge_overtemp_flag, 16'h0000);
      charge_fault_enable = 1'b0;
      thermistor_input = 16'h0050;
      tick(3);
      chk(charge_overtemp_flag, 16'h0000);
      charge_fault_enable = 1'b1;
      charge_overtemp_hold_time = 8'h00;
      tick(3);
      chk(charge_overtemp_flag, 16'h0000);
   endtask
   task t_flash;
      for (int i = 0; i < 3; i++) begin
         host.wr(8'(8'h3A + i), 5'h00, 8'(8'hA0 + i));
         host.wr(8'(8'h3A + i), 5'h1F, 8'(8'h50 + i));
      end
      host.wr(8'h3D, 5'h00, 8'hEE);
      chk(flash_addr_ok, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         host.rd(8'(8'h3A + i), 5'h00, rd);
         chk(rd, 16'(8'(8'hA0 + i)));
         host.rd(8'(8'h3A + i), 5'h1F, rd);
         chk(rd, 16'(8'(8'h50 + i)));
      end
      host.rd(8'h39, 5'h00, rd);
      chk(flash_addr_ok, 16'h0000);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      t_reset();
      t_meas();
      t_dsg();
      t_chg();
      t_flash();
      test_done();
   end
endmodule
`default_nettype wire
